//--- crtb_pkg.sv
package crtb_pkg;
  // system clock
  localparam int CLK_HZ       = 40_000_000;
  // time-division duplex frame
  localparam int TDD_CYCLE_US = 4800;
  localparam int TDD_OWN_PCT  = 50;
  localparam int TDD_HALF_CYC = CLK_HZ / 1_000_000 * TDD_CYCLE_US
                                * TDD_OWN_PCT / 100;
  localparam int LOSS_FRAMES  = 8;
  localparam logic [3:0] LOSS_LIMIT = 4'h8;
  // bit-rate detection
  localparam int ABD_TIMEOUT_S   = 15;
  localparam int ABD_TIMEOUT_CYC = CLK_HZ * ABD_TIMEOUT_S;
  localparam int N_RATES  = 4;
  localparam int RATE_W   = 2;
  localparam int RATE_KBPS [N_RATES] = '{125, 250, 500, 1000};
  localparam int RUN_W    = 10;
  localparam logic [4:0] ABD_MIN_RUNS = 5'h10;
  // frequency hopping
  localparam int CHAN_W   = 6;
  localparam logic [CHAN_W:0]   N_CHAN   = 7'h28;
  localparam logic [CHAN_W:0]   HOP_STEP = 7'h07;
  localparam logic [CHAN_W-1:0] CH_RDV   = 6'h00;
  // message path
  localparam int MSG_W       = 100;
  localparam int TXBUF_DEPTH = 128;
  localparam int RXBUF_DEPTH = 8;
  localparam logic [1:0] MAX_RETRY = 2'h2;

  typedef enum logic [1:0] {CRTB_TX_IDLE, CRTB_TX_CCA, CRTB_TX_SEND}
    crtb_tx_st_t;
  typedef enum logic {CRTB_LNK_SEARCH, CRTB_LNK_UP} crtb_link_t;

  // step is coprime to the channel count, so one lap visits each once
  function automatic logic [CHAN_W-1:0] crtb_hop_next(
    input logic [CHAN_W-1:0] ch);
    logic [CHAN_W:0] s;
    s = {1'b0, ch} + HOP_STEP;
    if (s >= N_CHAN) begin
      s = s - N_CHAN;
    end
    return s[CHAN_W-1:0];
  endfunction

  // {hit, rate index}; a run within one eighth of a nominal bit time
  function automatic logic [RATE_W:0] crtb_classify(
    input logic [RUN_W-1:0] w);
    logic [RATE_W:0] r;
    int              nom;
    r   = '0;
    nom = 0;
    for (int i = 0; i < N_RATES; i++) begin
      nom = CLK_HZ / (RATE_KBPS[i] * 1000);
      if (int'(w) >= nom - nom / 8 && int'(w) <= nom + nom / 8) begin
        r = {1'b1, RATE_W'(i)};
      end
    end
    return r;
  endfunction
endpackage

//--- crtb_fifo_if.sv
interface crtb_fifo_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic         flush;
  modport user (output push_valid, push_data, pop_ready, flush,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data);
endinterface

//--- crtb_fifo.sv
// depth must be a power of two
module crtb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic  sys_clk_i,
  input wire logic  rst_n_i,
  // queue ports
  crtb_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;
  logic         full;
  logic         empty;
  logic         do_push;
  logic         do_pop;

  assign empty   = (wr_ptr_ff == rd_ptr_ff);
  assign full    = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                   (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign do_push = q.push_valid && !full && !q.flush;
  assign do_pop  = q.pop_ready && !empty && !q.flush;

  assign q.push_ready = !full;
  assign q.pop_valid  = !empty;
  assign q.pop_data   = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (q.flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  // storage needs no reset: the pointers guard every read
  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= q.push_data;
    end
  end
endmodule

//--- crtb_top.sv
// Operation
// - Paired units share the radio by TDD; each owns half of each frame.
// - Each own interval starts on a new hopped channel, all used equally; the code stays on CH_RDV while searching and for the secondary's first reply.
// - Hopping draws from a set of forty channels.
// - Busy scheduled channel is skipped; send on the next free channel.
// - Channel-busy check is a build option; without it send regardless.
// - Every good local frame is acknowledged at once, before forwarding.
// - No arbitration across radio; remote frames queue for fresh arbitration.
// - Local bit rate is derived from observed bus traffic, or else adopted from the partner.
// - Radio link sets itself up without command, then moves messages.
// - No local rate by timeout after link up: adopt partner's, never redo.
// - Four supported bit rates, picked independently, with no default.
// - Transmit buffer of fixed depth; overflow discards its whole contents.
// - Unacknowledged packet resent in later intervals, at most twice.
module crtb_top import crtb_pkg::*; #(
  parameter int TDD_HALF = TDD_HALF_CYC,
  parameter int ABD_TMO  = ABD_TIMEOUT_CYC,
  parameter bit PRIMARY  = 1'b1,
  parameter bit LBT_EN   = 1'b1
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // local bus pin
  input  wire logic              can_rx_i,
  // local controller, received frames
  input  wire logic              mac_rx_valid_i,
  input  wire logic              mac_rx_crc_ok_i,
  input  wire logic [MSG_W-1:0]  mac_rx_msg_i,
  output logic                   can_ack_o,
  // local controller, frames to send
  output logic                   mac_tx_valid_o,
  input  wire logic              mac_tx_ready_i,
  output logic [MSG_W-1:0]       mac_tx_msg_o,
  // detected bit rate
  output logic [RATE_W-1:0]      bitrate_o,
  output logic                   bitrate_valid_o,
  // radio transmit
  output logic                   rf_tx_valid_o,
  input  wire logic              rf_tx_ready_i,
  output logic [CHAN_W-1:0]      rf_chan_o,
  output logic                   rf_tx_has_msg_o,
  output logic [MSG_W-1:0]       rf_tx_msg_o,
  output logic                   rf_tx_seq_o,
  output logic                   rf_tx_ack_o,
  output logic [RATE_W-1:0]      rf_tx_rate_o,
  output logic                   rf_tx_rate_vld_o,
  input  wire logic              rf_cca_busy_i,
  // radio receive
  input  wire logic              rf_rx_valid_i,
  input  wire logic              rf_rx_has_msg_i,
  input  wire logic [MSG_W-1:0]  rf_rx_msg_i,
  input  wire logic              rf_rx_seq_i,
  input  wire logic              rf_rx_ack_i,
  input  wire logic [RATE_W-1:0] rf_rx_rate_i,
  input  wire logic              rf_rx_rate_vld_i,
  // status
  output logic                   link_up_o,
  output logic                   txbuf_ovf_o,
  output logic                   msg_drop_o
);
  localparam int SLOT_W = $clog2(TDD_HALF);
  localparam int TMO_W  = $clog2(ABD_TMO + 1);
  localparam logic OWN_PHASE = PRIMARY ? 1'b0 : 1'b1;

  crtb_fifo_if #(.W(MSG_W)) txq ();
  crtb_fifo_if #(.W(MSG_W)) rxq ();

  crtb_fifo #(.W(MSG_W), .DEPTH(TXBUF_DEPTH)) u_txbuf (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .q         (txq.fifo)
  );
  crtb_fifo #(.W(MSG_W), .DEPTH(RXBUF_DEPTH)) u_rxbuf (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .q         (rxq.fifo)
  );

  logic [SLOT_W-1:0] slot_cnt_ff;
  logic              phase_ff;
  crtb_link_t        link_ff;
  logic [3:0]        loss_cnt_ff;
  logic              hold_ff;
  logic [CHAN_W-1:0] hop_ch_ff;
  logic [CHAN_W-1:0] tx_ch_ff;
  crtb_tx_st_t       tx_st_ff;
  logic              infl_ff;
  logic              acked_ff;
  logic [1:0]        retry_ff;
  logic              seq_ff;
  logic              ack_pend_ff;
  logic              rx_seq_ff;
  logic              rx_seen_ff;
  logic              can_meta_ff;
  logic              can_sync_ff;
  logic              can_prev_ff;
  logic [RUN_W-1:0]  run_ff;
  logic [RUN_W-1:0]  min_run_ff;
  logic [4:0]        runs_ff;
  logic [TMO_W-1:0]  tmo_ff;
  logic              tmo_run_ff;
  logic [RATE_W:0]   cls;
  logic              align;
  logic              iv_edge;
  logic              own_start;
  logic              hop_adv;
  logic              tx_go;
  logic              pop;
  logic              accept;
  logic              rx_new;
  logic              rx_dup;
  logic              rise;

  // tdd frame timer; the secondary locks its phase to the first packet heard
  assign align   = (link_ff == CRTB_LNK_SEARCH) && rf_rx_valid_i && !PRIMARY;
  assign iv_edge = (slot_cnt_ff == SLOT_W'(TDD_HALF - 1)) && !align;
  assign own_start = iv_edge && (phase_ff != OWN_PHASE);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_cnt_ff <= '0;
      phase_ff    <= 1'b0;
    end else if (align) begin
      slot_cnt_ff <= '0;
      phase_ff    <= ~OWN_PHASE;
    end else if (iv_edge) begin
      slot_cnt_ff <= '0;
      phase_ff    <= ~phase_ff;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 1'b1;
    end
  end

  // link setup and loss detection, no external command needed
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_ff     <= CRTB_LNK_SEARCH;
      loss_cnt_ff <= 4'h0;
    end else if (link_ff == CRTB_LNK_SEARCH) begin
      loss_cnt_ff <= 4'h0;
      if (rf_rx_valid_i) begin
        link_ff <= CRTB_LNK_UP;
      end
    end else if (rf_rx_valid_i) begin
      loss_cnt_ff <= 4'h0;
    end else if (loss_cnt_ff == LOSS_LIMIT) begin
      link_ff <= CRTB_LNK_SEARCH;
    end else if (own_start) begin
      loss_cnt_ff <= loss_cnt_ff + 4'h1;
    end
  end

  // both ends sit on the rendezvous channel while searching; the secondary
  // holds one interval so its first reply lands where the primary listens
  assign hop_adv = (link_ff == CRTB_LNK_UP) && !hold_ff;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hop_ch_ff <= CH_RDV;
      hold_ff   <= 1'b0;
    end else if (align) begin
      hop_ch_ff <= CH_RDV;
      hold_ff   <= 1'b1;
    end else if (link_ff == CRTB_LNK_SEARCH) begin
      hop_ch_ff <= CH_RDV;
    end else if (iv_edge) begin
      hold_ff <= 1'b0;
      if (hop_adv) begin
        hop_ch_ff <= crtb_hop_next(hop_ch_ff);
      end
    end
  end

  // transmit sequencer: hop, clear-channel check, then one packet
  assign tx_go = (tx_st_ff == CRTB_TX_CCA) && !(LBT_EN && rf_cca_busy_i);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_ff <= CRTB_TX_IDLE;
      tx_ch_ff <= CH_RDV;
    end else if (own_start) begin
      if (link_ff == CRTB_LNK_UP || PRIMARY) begin
        tx_st_ff <= CRTB_TX_CCA;
      end else begin
        tx_st_ff <= CRTB_TX_IDLE;
      end
      tx_ch_ff <= hop_adv ? crtb_hop_next(hop_ch_ff) : hop_ch_ff;
    end else if (iv_edge) begin
      tx_st_ff <= CRTB_TX_IDLE; // a send never spills into the partner's half
    end else begin
      case (tx_st_ff)
        CRTB_TX_CCA: begin
          if (tx_go) begin
            tx_st_ff <= CRTB_TX_SEND;
          end else begin
            tx_ch_ff <= crtb_hop_next(tx_ch_ff);
          end
        end
        CRTB_TX_SEND: begin
          if (rf_tx_ready_i) begin
            tx_st_ff <= CRTB_TX_IDLE;
          end
        end
        default: tx_st_ff <= CRTB_TX_IDLE;
      endcase
    end
  end

  // packet fields are frozen when the channel is found clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rf_tx_has_msg_o  <= 1'b0;
      rf_tx_msg_o      <= '0;
      rf_tx_seq_o      <= 1'b0;
      rf_tx_ack_o      <= 1'b0;
      rf_tx_rate_o     <= '0;
      rf_tx_rate_vld_o <= 1'b0;
    end else if (tx_go) begin
      rf_tx_has_msg_o  <= txq.pop_valid && (link_ff == CRTB_LNK_UP);
      rf_tx_msg_o      <= txq.pop_data;
      rf_tx_seq_o      <= seq_ff;
      rf_tx_ack_o      <= ack_pend_ff;
      rf_tx_rate_o     <= bitrate_o;
      rf_tx_rate_vld_o <= bitrate_valid_o;
    end
  end

  assign rf_tx_valid_o = (tx_st_ff == CRTB_TX_SEND);
  assign rf_chan_o     = (tx_st_ff != CRTB_TX_IDLE) ? tx_ch_ff : hop_ch_ff;

  // head of the buffer stays until acked or out of retries, keeping order
  assign pop = own_start && infl_ff && (acked_ff || retry_ff == MAX_RETRY);
  assign txq.pop_ready = pop;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      infl_ff    <= 1'b0;
      acked_ff   <= 1'b0;
      retry_ff   <= 2'h0;
      seq_ff     <= 1'b0;
      msg_drop_o <= 1'b0;
    end else begin
      msg_drop_o <= pop && !acked_ff;
      if (rf_rx_valid_i && rf_rx_ack_i && infl_ff) begin
        acked_ff <= 1'b1;
      end else if (own_start) begin
        acked_ff <= 1'b0;
      end
      if (txq.flush || pop) begin
        infl_ff  <= 1'b0;
        retry_ff <= 2'h0;
      end else if (own_start && infl_ff) begin
        retry_ff <= retry_ff + 2'h1;
      end else if (rf_tx_valid_o && rf_tx_ready_i && rf_tx_has_msg_o) begin
        infl_ff <= 1'b1;
      end
      if (pop) begin
        seq_ff <= ~seq_ff;
      end
    end
  end

  // local side: ack at once, queue for radio, flush whole buffer on overflow
  assign accept         = mac_rx_valid_i && mac_rx_crc_ok_i;
  assign txq.push_valid = accept;
  assign txq.push_data  = mac_rx_msg_i;
  assign txq.flush      = accept && !txq.push_ready;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      can_ack_o   <= 1'b0;
      txbuf_ovf_o <= 1'b0;
    end else begin
      can_ack_o   <= accept;
      txbuf_ovf_o <= txq.flush;
    end
  end

  // remote side: duplicates are acked but not replayed; a full queue
  // withholds the ack so the partner resends
  assign rx_new = !rx_seen_ff || (rf_rx_seq_i != rx_seq_ff);
  assign rx_dup = rf_rx_valid_i && rf_rx_has_msg_i && !rx_new;
  assign rxq.push_valid = rf_rx_valid_i && rf_rx_has_msg_i && rx_new &&
                          (link_ff == CRTB_LNK_UP);
  assign rxq.push_data  = rf_rx_msg_i;
  assign rxq.flush      = 1'b0;
  assign rxq.pop_ready  = mac_tx_ready_i;
  assign mac_tx_valid_o = rxq.pop_valid;
  assign mac_tx_msg_o   = rxq.pop_data;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_seq_ff   <= 1'b0;
      rx_seen_ff  <= 1'b0;
      ack_pend_ff <= 1'b0;
    end else begin
      if (rxq.push_valid && rxq.push_ready) begin
        rx_seq_ff  <= rf_rx_seq_i;
        rx_seen_ff <= 1'b1;
      end
      if ((rxq.push_valid && rxq.push_ready) || rx_dup) begin
        ack_pend_ff <= 1'b1;
      end else if (tx_go) begin
        ack_pend_ff <= 1'b0;
      end
    end
  end

  // bit-rate detection from the shortest dominant run seen on the pin
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      can_meta_ff <= 1'b1;
      can_sync_ff <= 1'b1;
      can_prev_ff <= 1'b1;
    end else begin
      can_meta_ff <= can_rx_i;
      can_sync_ff <= can_meta_ff;
      can_prev_ff <= can_sync_ff;
    end
  end

  assign rise = can_sync_ff && !can_prev_ff;
  assign cls  = crtb_classify(min_run_ff);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff     <= '0;
      min_run_ff <= '1;
      runs_ff    <= 5'h00;
    end else if (!can_sync_ff) begin
      if (run_ff != '1) begin
        run_ff <= run_ff + 1'b1;
      end
    end else if (rise) begin
      run_ff <= '0;
      if (runs_ff == ABD_MIN_RUNS) begin
        runs_ff    <= 5'h00;
        min_run_ff <= '1;
      end else begin
        runs_ff <= runs_ff + 5'h01;
        if (run_ff < min_run_ff) begin
          min_run_ff <= run_ff;
        end
      end
    end
  end

  // once a rate is held it is never given up, even across link loss
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bitrate_o       <= '0;
      bitrate_valid_o <= 1'b0;
      tmo_ff          <= '0;
      tmo_run_ff      <= 1'b0;
    end else if (!bitrate_valid_o) begin
      if (link_ff == CRTB_LNK_UP) begin
        tmo_run_ff <= 1'b1;
      end
      if (tmo_run_ff && tmo_ff != TMO_W'(ABD_TMO)) begin
        tmo_ff <= tmo_ff + 1'b1;
      end
      if (runs_ff == ABD_MIN_RUNS && cls[RATE_W]) begin
        bitrate_o       <= cls[RATE_W-1:0];
        bitrate_valid_o <= 1'b1;
      end else if (tmo_ff == TMO_W'(ABD_TMO) && rf_rx_valid_i &&
                   rf_rx_rate_vld_i) begin
        bitrate_o       <= rf_rx_rate_i;
        bitrate_valid_o <= 1'b1;
      end
    end
  end

  assign link_up_o = (link_ff == CRTB_LNK_UP);
endmodule

//--- crtb_top_props.sv
module crtb_props import crtb_pkg::*; #(
  parameter int TDD_HALF = 200,
  parameter bit LBT_EN   = 1'b1
) (
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  // local side
  input wire logic              mac_rx_valid_i,
  input wire logic              mac_rx_crc_ok_i,
  input wire logic              can_ack_o,
  input wire logic              mac_tx_valid_o,
  input wire logic              mac_tx_ready_i,
  input wire logic [MSG_W-1:0]  mac_tx_msg_o,
  input wire logic [RATE_W-1:0] bitrate_o,
  input wire logic              bitrate_valid_o,
  input wire logic              txbuf_ovf_o,
  // radio side
  input wire logic              rf_tx_valid_o,
  input wire logic [CHAN_W-1:0] rf_chan_o,
  input wire logic [MSG_W-1:0]  rf_tx_msg_o,
  input wire logic              rf_cca_busy_i,
  input wire logic              rf_rx_valid_i,
  input wire logic              link_up_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // starts large so the first packet after reset is not judged
  int gap_ff;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_ff <= 100000;
    end else if ($rose(rf_tx_valid_o)) begin
      gap_ff <= 0;
    end else if (gap_ff < 100000) begin
      gap_ff <= gap_ff + 1;
    end
  end
  chk_ack_good: assert property (
    mac_rx_valid_i && mac_rx_crc_ok_i |=> can_ack_o)
    else $error("good frame not acknowledged");
  chk_ack_cause: assert property (
    can_ack_o |-> $past(mac_rx_valid_i && mac_rx_crc_ok_i))
    else $error("acknowledge without good frame");
  chk_chan_set: assert property (rf_chan_o < N_CHAN)
    else $error("channel outside set");
  chk_cca_clear: assert property (
    LBT_EN && $rose(rf_tx_valid_o) |-> !$past(rf_cca_busy_i))
    else $error("sent on busy channel");
  chk_pkt_stable: assert property (
    rf_tx_valid_o && $past(rf_tx_valid_o)
      |-> $stable(rf_chan_o) && $stable(rf_tx_msg_o))
    else $error("packet changed while offered");
  chk_one_per_slot: assert property (
    $rose(rf_tx_valid_o) |-> gap_ff > TDD_HALF)
    else $error("two packets in one interval");
  chk_rate_sticky: assert property (
    bitrate_valid_o |=> bitrate_valid_o && $stable(bitrate_o))
    else $error("bit rate changed after lock");
  chk_replay_hold: assert property (
    mac_tx_valid_o && !mac_tx_ready_i
      |=> mac_tx_valid_o && $stable(mac_tx_msg_o))
    else $error("replay word dropped or changed");
  chk_link_by_rx: assert property (rf_rx_valid_i |=> link_up_o)
    else $error("link not up after packet");
  chk_ovf_cause: assert property (
    txbuf_ovf_o |-> $past(mac_rx_valid_i && mac_rx_crc_ok_i))
    else $error("overflow without incoming frame");
endmodule

bind crtb_top crtb_props #(.TDD_HALF(TDD_HALF), .LBT_EN(LBT_EN)) i_props (
  .sys_clk_i, .rst_n_i, .mac_rx_valid_i, .mac_rx_crc_ok_i, .can_ack_o,
  .mac_tx_valid_o, .mac_tx_ready_i, .mac_tx_msg_o, .bitrate_o,
  .bitrate_valid_o, .txbuf_ovf_o, .rf_tx_valid_o, .rf_chan_o, .rf_tx_msg_o,
  .rf_cca_busy_i, .rf_rx_valid_i, .link_up_o);

//--- crtb_peer.sv
module crtb_peer import crtb_pkg::*; #(
  parameter int HALF = 200
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // packets from the unit
  input  wire logic             pkt_valid_i,
  output logic                  pkt_ready_o,
  input  wire logic             pkt_has_msg_i,
  input  wire logic [MSG_W-1:0] pkt_msg_i,
  input  wire logic             pkt_seq_i,
  // packets to the unit
  output logic                  rx_valid_o,
  output logic                  rx_has_msg_o,
  output logic [MSG_W-1:0]      rx_msg_o,
  output logic                  rx_seq_o,
  output logic                  rx_ack_o,
  output logic [RATE_W-1:0]     rx_rate_o,
  output logic                  rx_rate_vld_o,
  // scenario control
  input  wire logic             mute_i,
  input  wire logic             ack_en_i,
  input  wire logic             slow_i,
  input  wire logic [7:0]       req_i,
  input  wire logic [MSG_W-1:0] msg_i
);
  logic [MSG_W-1:0] got_q [$];
  int               n_msg, n_pkt, cnt, dly;
  logic [7:0]       sent;
  logic             ack_due, last_seq, fresh;
  initial n_msg = 0;
  initial n_pkt = 0;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pkt_ready_o <= 1'b0;
      rx_valid_o <= 1'b0;
      {rx_has_msg_o, rx_seq_o, rx_ack_o, rx_rate_vld_o} <= 4'h0;
      rx_msg_o <= '0;
      rx_rate_o <= 2'h0;
      cnt <= 0;
      dly <= 0;
      sent <= req_i;
      fresh <= 1'b1;
      ack_due <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      // released fields flip so a stale value never looks current
      rx_msg_o <= ~rx_msg_o;
      rx_has_msg_o <= ~rx_has_msg_o;
      rx_ack_o <= ~rx_ack_o;
      rx_rate_vld_o <= ~rx_rate_vld_o;
      {rx_seq_o, rx_rate_o} <= ~{rx_seq_o, rx_rate_o};
      pkt_ready_o <= pkt_valid_i && !pkt_ready_o && (!slow_i || dly == 3);
      dly <= (pkt_valid_i && !pkt_ready_o) ? dly + 1 : 0;
      if (pkt_valid_i && pkt_ready_o) begin
        n_pkt <= n_pkt + 1;
        cnt <= HALF;
        ack_due <= pkt_has_msg_i;
        if (pkt_has_msg_i) begin
          n_msg <= n_msg + 1;
          if (fresh || pkt_seq_i != last_seq) begin
            got_q.push_back(pkt_msg_i);
          end
          fresh <= 1'b0;
          last_seq <= pkt_seq_i;
        end
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
        if (cnt == 1 && !mute_i) begin
          rx_valid_o <= 1'b1;
          rx_has_msg_o <= (sent != req_i);
          rx_msg_o <= msg_i;
          rx_seq_o <= sent[0];
          rx_ack_o <= ack_en_i && ack_due;
          rx_rate_o <= 2'h1;
          rx_rate_vld_o <= 1'b1;
          if (sent != req_i) begin
            sent <= sent + 8'h01;
          end
        end
      end
    end
  end
endmodule

//--- crtb_top_tb.sv
module crtb_top_tb import crtb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 200;
  logic             sys_clk_i, rst_n_i, can_rx_i, can_ack_o, mac_rx_valid_i;
  logic             mac_rx_crc_ok_i, mac_tx_valid_o, mac_tx_ready_i;
  logic             bitrate_valid_o, rf_tx_valid_o, rf_tx_ready_i;
  logic             rf_tx_has_msg_o, rf_tx_seq_o, rf_tx_ack_o;
  logic             rf_tx_rate_vld_o, rf_cca_busy_i, rf_rx_valid_i;
  logic             rf_rx_has_msg_i, rf_rx_seq_i, rf_rx_ack_i;
  logic             rf_rx_rate_vld_i, link_up_o, txbuf_ovf_o, msg_drop_o;
  logic             mute, ack_en, slow, seen;
  logic [RATE_W-1:0] bitrate_o, rf_tx_rate_o, rf_rx_rate_i;
  logic [CHAN_W-1:0] rf_chan_o;
  logic [7:0]       req;
  logic [MSG_W-1:0] mac_rx_msg_i, mac_tx_msg_o, rf_tx_msg_o, rf_rx_msg_i;
  logic [MSG_W-1:0] pmsg;
  int               miscompares, n_tests, n0, base;

  crtb_top #(.TDD_HALF(HALF), .ABD_TMO(2000)) i_dut (
    .sys_clk_i, .rst_n_i, .can_rx_i, .mac_rx_valid_i, .mac_rx_crc_ok_i,
    .mac_rx_msg_i, .can_ack_o, .mac_tx_valid_o, .mac_tx_ready_i,
    .mac_tx_msg_o, .bitrate_o, .bitrate_valid_o, .rf_tx_valid_o,
    .rf_tx_ready_i, .rf_chan_o, .rf_tx_has_msg_o, .rf_tx_msg_o,
    .rf_tx_seq_o, .rf_tx_ack_o, .rf_tx_rate_o, .rf_tx_rate_vld_o,
    .rf_cca_busy_i, .rf_rx_valid_i, .rf_rx_has_msg_i, .rf_rx_msg_i,
    .rf_rx_seq_i, .rf_rx_ack_i, .rf_rx_rate_i, .rf_rx_rate_vld_i,
    .link_up_o, .txbuf_ovf_o, .msg_drop_o);

  crtb_peer #(.HALF(HALF)) i_peer (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pkt_valid_i(rf_tx_valid_o),
    .pkt_ready_o(rf_tx_ready_i), .pkt_has_msg_i(rf_tx_has_msg_o),
    .pkt_msg_i(rf_tx_msg_o), .pkt_seq_i(rf_tx_seq_o),
    .rx_valid_o(rf_rx_valid_i), .rx_has_msg_o(rf_rx_has_msg_i),
    .rx_msg_o(rf_rx_msg_i), .rx_seq_o(rf_rx_seq_i), .rx_ack_o(rf_rx_ack_i),
    .rx_rate_o(rf_rx_rate_i), .rx_rate_vld_o(rf_rx_rate_vld_i),
    .mute_i(mute), .ack_en_i(ack_en), .slow_i(slow), .req_i(req),
    .msg_i(pmsg));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask

  task automatic chk(input string nm, input logic [MSG_W-1:0] exp,
                     input logic [MSG_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst_n_i = 1'b0;
    tick(8);
    rst_n_i = 1'b1;
  endtask

  task automatic wait_link;
    for (int i = 0; i < 8 * HALF && link_up_o !== 1'b1; i++) tick(1);
    chk("link_up", 1, link_up_o);
  endtask

  // caller releases the valid strobe after the last frame
  task automatic frame(input logic [MSG_W-1:0] m, input logic ok);
    mac_rx_msg_i = m;
    mac_rx_crc_ok_i = ok;
    mac_rx_valid_i = 1'b1;
    tick(1);
    chk("can_ack", ok, can_ack_o);
  endtask

  task automatic t_autobaud;
    chk("no_default_rate", 0, bitrate_valid_o);
    repeat (20) begin
      can_rx_i = 1'b0;
      tick(80);
      can_rx_i = 1'b1;
      tick(80);
    end
    chk("rate_valid", 1, bitrate_valid_o);
    chk("rate", 2, bitrate_o);
  endtask

  task automatic t_forward;
    slow = 1'b1;
    base = i_peer.got_q.size();
    frame(100'hA1, 1'b1);
    frame(100'hB2, 1'b0);
    frame(100'hC3, 1'b1);
    frame(100'hD4, 1'b1);
    mac_rx_valid_i = 1'b0;
    for (int i = 0; i < 20 * HALF && i_peer.got_q.size() < base + 3; i++)
      tick(1);
    chk("fwd0", 100'hA1, i_peer.got_q[base]);
    chk("fwd1", 100'hC3, i_peer.got_q[base + 1]);
    chk("fwd2", 100'hD4, i_peer.got_q[base + 2]);
    slow = 1'b0;
  endtask

  task automatic t_replay;
    pmsg = 100'h5A5;
    req = req + 8'h01;
    for (int i = 0; i < 6 * HALF && mac_tx_valid_o !== 1'b1; i++) tick(1);
    tick(5);
    chk("replay_held", 1, mac_tx_valid_o);
    chk("replay_msg", 100'h5A5, mac_tx_msg_o);
    mac_tx_ready_i = 1'b1;
    tick(1);
    mac_tx_ready_i = 1'b0;
    chk("replay_pop", 0, mac_tx_valid_o);
    tick(2 * HALF);
    chk("tx_ack", 1, rf_tx_ack_o);
  endtask

  task automatic t_retry;
    ack_en = 1'b0;
    n0 = i_peer.n_msg;
    seen = 1'b0;
    frame(100'hE5, 1'b1);
    mac_rx_valid_i = 1'b0;
    for (int i = 0; i < 12 * HALF && !seen; i++) begin
      tick(1);
      seen = (msg_drop_o === 1'b1);
    end
    chk("dropped", 1, seen);
    chk("sends", 3, i_peer.n_msg - n0);
    ack_en = 1'b1;
  endtask

  task automatic t_cca;
    rf_cca_busy_i = 1'b1;
    n0 = i_peer.n_pkt;
    tick(5 * HALF);
    chk("busy_blocks", n0, i_peer.n_pkt);
    rf_cca_busy_i = 1'b0;
    tick(4 * HALF);
    chk("resumed", 1, i_peer.n_pkt > n0);
  endtask

  task automatic t_ovf;
    seen = 1'b0;
    for (int k = 0; k < 131; k++) begin
      frame(MSG_W'(k), 1'b1);
      if (txbuf_ovf_o === 1'b1) seen = 1'b1;
    end
    mac_rx_valid_i = 1'b0;
    chk("overflow", 1, seen);
  endtask

  task automatic t_adopt;
    do_reset();
    wait_link();
    tick(2000 + 4 * HALF);
    chk("adopt_valid", 1, bitrate_valid_o);
    chk("adopt_rate", 1, bitrate_o);
    mute = 1'b1;
    tick(20 * HALF);
    chk("link_lost", 0, link_up_o);
    mute = 1'b0;
    wait_link();
    tick(4 * HALF);
    chk("rate_kept", 1, bitrate_o);
    chk("tx_rate", 3'h5, {rf_tx_rate_vld_o, rf_tx_rate_o});
  endtask

  // comfortably above the sum of all scenario spans
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    miscompares++;
    wrap_up();
  end

  initial begin
    {can_rx_i, mac_rx_valid_i, mac_rx_crc_ok_i, mac_tx_ready_i} = 4'h8;
    {rf_cca_busy_i, mute, ack_en, slow} = 4'h6;
    mac_rx_msg_i = '0;
    pmsg = '0;
    req = 8'h00;
    miscompares = 0;
    n_tests = 0;
    do_reset();
    t_autobaud();
    mute = 1'b0;
    wait_link();
    t_forward();
    t_replay();
    t_retry();
    t_cca();
    t_ovf();
    t_adopt();
    wrap_up();
  end
endmodule
